/* pkg/rtsq_params.svh */
// constants for the receive timeout stop qualifier
`ifndef RTSQ_PARAMS_SVH
`define RTSQ_PARAMS_SVH
// register offsets
`define RTSQ_ADDR_CTRL 8'h00
`define RTSQ_ADDR_TIMEOUT 8'h04
`define RTSQ_ADDR_STATUS 8'h08
`define RTSQ_ADDR_IRQ_STATUS 8'h0c
`define RTSQ_ADDR_IRQ_ENABLE 8'h10
`define RTSQ_ADDR_IRQ_CLEAR 8'h14
`define RTSQ_ADDR_COMMAND 8'h18
// control register fields
`define RTSQ_CTRL_CS_MASK 0
`define RTSQ_CTRL_SQ_MASK 1
`define RTSQ_CTRL_PQ_MASK 2
`define RTSQ_CTRL_AND_OR 3
// reset: all masks clear with the or selector, so the timeout is always stopped
`define RTSQ_CTRL_RESET 4'h8
// command register codes
`define RTSQ_CMD_RX 8'h01
`define RTSQ_CMD_ABORT 8'h02
// interrupt bits
`define RTSQ_IRQ_DATA_READY 0
`define RTSQ_IRQ_TIMEOUT 1
`define RTSQ_IRQ_ABORT 2
`define RTSQ_IRQ_STOPPED 3
`define RTSQ_IRQ_WIDTH 4
// default receive timeout in clock cycles
`define RTSQ_TIMEOUT_RESET 16'h0fa0
`endif

/* pkg/rtsq_pkg.sv */
// types for the receive timeout stop qualifier
`default_nettype none
package rtsq_pkg;
    typedef enum logic [3:0] {
        RTSQ_IDLE = 4'b0001,
        RTSQ_RUN = 4'b0010,
        RTSQ_FROZEN = 4'b0100,
        RTSQ_DONE = 4'b1000
    } rtsq_state_type;
endpackage
`default_nettype wire

/* hdl/rtsq_stop_logic.sv */
// combinational decision whether the receive timeout stops
`timescale 1ns/1ps
`default_nettype none
module rtsq_stop_logic (
    input wire logic [2:0] stop_mask,   // cs, sync, preamble masks
    input wire logic [2:0] above,       // indicators above threshold
    input wire logic and_or_select,     // 0 and, 1 or
    input wire logic always_stop,       // all masks clear, or mode
    output logic stop_now               // timeout stop condition
);
    // masked and/or; a single mask gives the same answer either way
    always_comb begin
        if (stop_mask == 3'h0) begin
            stop_now = always_stop;
        end else if (and_or_select) begin
            stop_now = |(stop_mask & above);
        end else begin
            stop_now = &(above | ~stop_mask);
        end
    end
endmodule // rtsq_stop_logic
`default_nettype wire

/* hdl/rtsq_qualifier.sv */
// receive timeout stop qualifier with register port and interrupt
`timescale 1ns/1ps
`include "rtsq_params.svh"
`default_nettype none
module rtsq_qualifier
    import rtsq_pkg::*;
(
    input wire logic clk,                // 20 MHz clock
    input wire logic rst,                // async reset, high
    input wire logic [7:0] addr,         // register byte address
    input wire logic [31:0] wdata,       // write data
    input wire logic wr,                 // write strobe
    input wire logic rd,                 // read strobe
    output logic [31:0] rdata,           // read data, cycle after rd
    input wire logic rssi_above,         // carrier sense above threshold
    input wire logic sync_quality_indicator,     // sync quality above threshold
    input wire logic preamble_quality_indicator, // preamble quality above threshold
    input wire logic packet_done,        // packet fully received, one cycle
    output logic rx_active,              // device in receive
    output logic packet_discard,         // drop current packet, one cycle
    output logic data_ready,             // packet accepted, one cycle
    output logic irq                     // level interrupt
);
    // synchronised indicators, two flops each
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] next_sync_a;
    logic [2:0] next_sync_b;

    // configuration
    logic [3:0] ctrl;
    logic [3:0] next_ctrl;
    logic [15:0] timeout_len;
    logic [15:0] next_timeout_len;

    // control fields by name
    logic [2:0] stop_mask;
    logic and_or_select;

    // timer state
    rtsq_state_type state;
    rtsq_state_type next_state;
    logic [15:0] count;
    logic [15:0] next_count;
    logic next_rx_active;
    logic next_discard;
    logic next_ready;

    // interrupt state
    logic [`RTSQ_IRQ_WIDTH-1:0] irq_stat;
    logic [`RTSQ_IRQ_WIDTH-1:0] next_irq_stat;
    logic [`RTSQ_IRQ_WIDTH-1:0] irq_en;
    logic [`RTSQ_IRQ_WIDTH-1:0] next_irq_en;
    logic [`RTSQ_IRQ_WIDTH-1:0] events;
    logic next_irq;

    // read path
    logic [31:0] next_rdata;

    // decoded strobes, shared by all groups
    logic wr_ctrl;
    logic wr_timeout;
    logic wr_irq_en;
    logic wr_clear;
    logic wr_cmd_rx;
    logic wr_cmd_abort;

    // stop decision
    logic stop_now;
    logic stop_eff;

    // one strobe at one register offset; every write decoder below uses this
    function automatic logic rtsq_hit(input logic strobe, input logic [7:0] at,
        input logic [7:0] offset);
        return strobe && (at == offset);
    endfunction

    // interrupt field of a written word, shared by enable and clear
    function automatic logic [`RTSQ_IRQ_WIDTH-1:0] rtsq_irq_field(input logic [31:0] w);
        return w[`RTSQ_IRQ_WIDTH-1:0];
    endfunction

    // receive stays open while the timer runs or is frozen
    function automatic logic rtsq_in_rx(input rtsq_state_type s);
        return (s == RTSQ_RUN) || (s == RTSQ_FROZEN);
    endfunction

    // timer ends on the cycle it would count through one
    function automatic logic rtsq_expiring(input logic [15:0] c);
        return c <= 16'h0001;
    endfunction

    // status word: count above, synchronised levels and state below
    function automatic logic [31:0] rtsq_status_word(input logic [15:0] c,
        input logic [2:0] lv, input rtsq_state_type s);
        return {c, 9'h0, lv, s};
    endfunction

    // control fields; mask order matches the indicator order in sync_b
    assign stop_mask = ctrl[2:0];
    assign and_or_select = ctrl[`RTSQ_CTRL_AND_OR];

    // all-zero masks: selector 1 means always stopped, 0 means never
    rtsq_stop_logic u_stop (
        .stop_mask(stop_mask),
        .above(sync_b),
        .and_or_select(and_or_select),
        .always_stop(and_or_select),
        .stop_now(stop_now)
    );
    assign stop_eff = stop_now;

    // strobe decode; command codes other than start and abort are ignored
    always_comb begin
        wr_ctrl = rtsq_hit(wr, addr, `RTSQ_ADDR_CTRL);
        wr_timeout = rtsq_hit(wr, addr, `RTSQ_ADDR_TIMEOUT);
        wr_irq_en = rtsq_hit(wr, addr, `RTSQ_ADDR_IRQ_ENABLE);
        wr_clear = rtsq_hit(wr, addr, `RTSQ_ADDR_IRQ_CLEAR);
        wr_cmd_rx = rtsq_hit(wr, addr, `RTSQ_ADDR_COMMAND) && wdata[7:0] == `RTSQ_CMD_RX;
        wr_cmd_abort = rtsq_hit(wr, addr, `RTSQ_ADDR_COMMAND) && wdata[7:0] == `RTSQ_CMD_ABORT;
    end

    // synchroniser: second stage is the only reader of the first
    always_comb begin
        next_sync_a = {preamble_quality_indicator, sync_quality_indicator, rssi_above};
        next_sync_b = sync_a;
    end

    // configuration writes; a new mask applies to a run already open
    always_comb begin
        next_ctrl = ctrl;
        next_timeout_len = timeout_len;
        next_irq_en = irq_en;
        if (wr_ctrl) begin
            next_ctrl = wdata[3:0];
        end
        if (wr_timeout) begin
            next_timeout_len = wdata[15:0];
        end
        if (wr_irq_en) begin
            next_irq_en = rtsq_irq_field(wdata);
        end
    end

    // timer state machine
    always_comb begin
        next_state = state;
        next_count = count;
        next_discard = 1'b0;
        next_ready = 1'b0;
        events = '0;
        case (state)
            // idle: only a start command opens receive
            RTSQ_IDLE: begin
                if (wr_cmd_rx) begin
                    next_state = RTSQ_RUN;
                    next_count = timeout_len;
                end
            end
            // run: abort first, then stop, then expiry
            RTSQ_RUN: begin
                if (wr_cmd_abort) begin
                    next_state = RTSQ_IDLE;
                    next_discard = 1'b1;
                    events[`RTSQ_IRQ_ABORT] = 1'b1;
                end else if (stop_eff) begin
                    // a packet ending in the stop cycle goes straight to done with the ready pulse
                    next_state = packet_done ? RTSQ_DONE : RTSQ_FROZEN;
                    events[`RTSQ_IRQ_STOPPED] = 1'b1;
                    next_ready = packet_done;
                    events[`RTSQ_IRQ_DATA_READY] = packet_done;
                end else if (rtsq_expiring(count)) begin
                    next_state = RTSQ_IDLE;
                    next_discard = 1'b1;
                    events[`RTSQ_IRQ_TIMEOUT] = 1'b1;
                end else begin
                    // packets done while running without a stop are dropped, not held
                    next_count = count - 16'h0001;
                end
            end
            RTSQ_FROZEN: begin
                // no expiry here; only abort or a packet can end it
                if (wr_cmd_abort) begin
                    next_state = RTSQ_IDLE;
                    next_discard = 1'b1;
                    events[`RTSQ_IRQ_ABORT] = 1'b1;
                end else if (packet_done) begin
                    next_state = RTSQ_DONE;
                    next_ready = 1'b1;
                    events[`RTSQ_IRQ_DATA_READY] = 1'b1;
                end
            end
            // done: one cycle for the ready pulse, then idle
            RTSQ_DONE: begin
                next_state = RTSQ_IDLE;
            end
            // a corrupted state code falls back to idle
            default: begin
                next_state = RTSQ_IDLE;
            end
        endcase
        // receive flag follows the next state so it changes with it
        next_rx_active = rtsq_in_rx(next_state);
    end

    // sticky status: set wins over clear
    always_comb begin
        next_irq_stat = irq_stat;
        if (wr_clear) begin
            next_irq_stat = irq_stat & ~rtsq_irq_field(wdata);
        end
        next_irq_stat = next_irq_stat | events;
        // built from next values, so the level never lags the status
        next_irq = |(next_irq_stat & next_irq_en);
    end

    // read mux; unmapped, clear and command offsets read as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (rd) begin
            case (addr)
                `RTSQ_ADDR_CTRL: next_rdata = {28'h0, ctrl};
                `RTSQ_ADDR_TIMEOUT: next_rdata = {16'h0, timeout_len};
                `RTSQ_ADDR_STATUS: next_rdata = rtsq_status_word(count, sync_b, state);
                `RTSQ_ADDR_IRQ_STATUS: next_rdata = {28'h0, irq_stat};
                `RTSQ_ADDR_IRQ_ENABLE: next_rdata = {28'h0, irq_en};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // synchroniser flops; reset reads as below threshold
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    // configuration registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= `RTSQ_CTRL_RESET;
            timeout_len <= `RTSQ_TIMEOUT_RESET;
            irq_en <= 4'h0;
        end else begin
            ctrl <= next_ctrl;
            timeout_len <= next_timeout_len;
            irq_en <= next_irq_en;
        end
    end

    // timer registers; the pulse outputs come straight from here
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= RTSQ_IDLE;
            count <= 16'h0000;
            rx_active <= 1'b0;
            packet_discard <= 1'b0;
            data_ready <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            rx_active <= next_rx_active;
            packet_discard <= next_discard;
            data_ready <= next_ready;
        end
    end

    // interrupt registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat <= 4'h0;
            irq <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq <= next_irq;
        end
    end

    // read data register, zero except the cycle after a read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule // rtsq_qualifier
`default_nettype wire

/* testbench/rtsq_qualifier_chk.sv */
// port assertions for the stop qualifier
`timescale 1ns/1ps
`include "rtsq_params.svh"
`default_nettype none
module rtsq_qualifier_chk (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic [7:0] addr, // address
    input wire logic [31:0] wdata, // data
    input wire logic wr, // write
    input wire logic rssi_above, // cs
    input wire logic sync_quality_indicator, // sq
    input wire logic preamble_quality_indicator, // pq
    input wire logic packet_done, // end
    input wire logic rx_active, // rx
    input wire logic packet_discard, // drop
    input wire logic data_ready // accept
);
    logic [3:0] ctrl;
    logic [5:0] sy;
    logic seen;
    logic cond;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // mirror masks and two-flop sync, so the gate is judged as the device sees it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= `RTSQ_CTRL_RESET;
            sy <= 6'h00;
            seen <= 1'b0;
        end else begin
            if (wr && addr == `RTSQ_ADDR_CTRL) ctrl <= wdata[3:0];
            sy <= {sy[2:0], preamble_quality_indicator, sync_quality_indicator, rssi_above};
            seen <= rx_active && (seen || cond);
        end
    end
    // all masks clear: the selector alone decides
    assign cond = (ctrl[2:0] == 3'h0) ? ctrl[3] : ctrl[3] ? |(ctrl[2:0] & sy[5:3])
        : ((ctrl[2:0] & sy[5:3]) == ctrl[2:0]);
    property p_gate; data_ready |-> seen; endproperty
    property p_done; rx_active && !wr && (seen || cond) && packet_done |=> data_ready; endproperty
    property p_cause; $fell(rx_active) |-> packet_discard || data_ready; endproperty
    property p_nostop; $fell(rx_active) && !seen |-> packet_discard; endproperty
    property p_excl; packet_discard |-> !data_ready && !rx_active; endproperty
    property p_abort;
        wr && addr == `RTSQ_ADDR_COMMAND && wdata[7:0] == `RTSQ_CMD_ABORT && rx_active
            |=> packet_discard ##1 !packet_discard;
    endproperty
    a_gate: assert property (p_gate) else $error("ready without stop");
    a_done: assert property (p_done) else $error("stopped packet lost");
    a_cause: assert property (p_cause) else $error("silent exit");
    a_nostop: assert property (p_nostop) else $error("no discard");
    a_excl: assert property (p_excl) else $error("discard clash");
    a_abort: assert property (p_abort) else $error("abort ignored");
    c_ready: cover property (data_ready);
    c_expire: cover property (packet_discard && !$past(wr));
    c_abort: cover property (wr && addr == `RTSQ_ADDR_COMMAND && rx_active);
endmodule // rtsq_qualifier_chk
bind rtsq_qualifier rtsq_qualifier_chk u_chk (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rssi_above(rssi_above),
    .sync_quality_indicator(sync_quality_indicator),
    .preamble_quality_indicator(preamble_quality_indicator), .packet_done(packet_done),
    .rx_active(rx_active), .packet_discard(packet_discard), .data_ready(data_ready));
`default_nettype wire

/* testbench/rtsq_host_model.sv */
// host side master of the register port
`timescale 1ns/1ps
`include "rtsq_params.svh"
`default_nettype none
module rtsq_host_model (
    input wire logic clk, // clock
    input wire logic [31:0] rdata, // read data
    output logic [7:0] addr, // address
    output logic [31:0] wdata, // data
    output logic wr, // write
    output logic rd // read
);
    // idle bus at time zero
    initial begin
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
    end
    // one-cycle strobe, then a quiet edge so strobes never double up
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d; // stale data must not look valid
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] q);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 q = rdata;
    endtask
    // only way out when a stop without sync keeps receive open
    task automatic abort_rx();
        wr_reg(`RTSQ_ADDR_COMMAND, 32'(`RTSQ_CMD_ABORT));
    endtask
endmodule // rtsq_host_model
`default_nettype wire

/* testbench/rx_timeout_stop_qualifier_tb_top.sv */
// self-checking bench for the stop qualifier
`timescale 1ns/1ps
`include "rtsq_params.svh"
`default_nettype none
module rx_timeout_stop_qualifier_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] ind = 3'h0;
    logic packet_done = 1'b0;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, q;
    logic wr, rd, rx_active, packet_discard, data_ready, irq, exp, d;
    integer seed = 32'h0fabf6e3;
    int err_total = 0;
    int total_checks = 0;
    always #25 clk = ~clk;
    rtsq_host_model host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd));
    rtsq_qualifier dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .rssi_above(ind[0]), .sync_quality_indicator(ind[1]),
        .preamble_quality_indicator(ind[2]), .packet_done(packet_done), .irq(irq),
        .rx_active(rx_active), .packet_discard(packet_discard), .data_ready(data_ready));
    // expected stop for control nibble c and indicator levels s
    function automatic logic stop_exp(input logic [3:0] c, input logic [2:0] s);
        if (c[2:0] == 3'h0) return c[3];
        return c[3] ? |(c[2:0] & s) : ((c[2:0] & s) == c[2:0]);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // every control nibble once, random levels, last one all-or corner
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        host.rd_reg(`RTSQ_ADDR_CTRL, q);
        chk(q, 32'(`RTSQ_CTRL_RESET));
        host.wr_reg(`RTSQ_ADDR_TIMEOUT, 32'd40);
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            ind <= (k == 15) ? 3'h4 : 3'($random(seed));
            host.wr_reg(`RTSQ_ADDR_CTRL, 32'(k));
            host.wr_reg(`RTSQ_ADDR_COMMAND, 32'(`RTSQ_CMD_RX));
            repeat (4) @(posedge clk);
            packet_done <= 1'b1;
            @(posedge clk);
            packet_done <= 1'b0;
            exp = stop_exp(4'(k), ind);
            d = 1'b0;
            #1 chk(32'(data_ready), 32'(exp));
            for (int n = 0; n < 60 && rx_active === 1'b1; n++) begin
                @(posedge clk);
                #1 d = d | packet_discard;
            end
            chk(32'({d, rx_active}), exp ? 32'h0 : 32'h2);
        end
        // abort while frozen
        @(posedge clk);
        ind <= 3'h7;
        host.wr_reg(`RTSQ_ADDR_CTRL, 32'hb);
        host.wr_reg(`RTSQ_ADDR_COMMAND, 32'(`RTSQ_CMD_RX));
        repeat (4) @(posedge clk);
        host.abort_rx();
        #1 chk(32'({packet_discard, rx_active}), 32'h2);
        host.rd_reg(`RTSQ_ADDR_STATUS, q);
        chk(32'(q[6:0]), 32'h71);
        host.rd_reg(`RTSQ_ADDR_IRQ_STATUS, q);
        chk(32'({q[3:0], 3'h0, irq}), 32'hf0);
        host.wr_reg(`RTSQ_ADDR_IRQ_ENABLE, 32'h2);
        @(posedge clk);
        #1 chk(32'(irq), 32'h1);
        host.wr_reg(`RTSQ_ADDR_IRQ_CLEAR, 32'h2);
        @(posedge clk);
        #1 chk(32'(irq), 32'h0);
        host.rd_reg(8'h40, q);
        chk(q, 32'h0);
        final_report();
    end
endmodule // rx_timeout_stop_qualifier_tb_top
`default_nettype wire
